//--- rtl/fle_apb_slave.sv
// APB slave front end with one wait state per transfer, more for a write while the core is busy.
// Assumes the core answers rdata and hit combinationally from addr.
`timescale 1ns/1ps
`default_nettype none
`include "fle_defines.svh"
module fle_apb_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  fle_reg_if.slave rb
);
  fle_pkg::fle_apb_s r, nxt;

  // Address and data go straight to the core; write commits on the ready edge
  assign rb.addr = paddr;
  assign rb.wdata = pwdata;
  assign rb.wr = psel & penable & r.pready & pwrite & rb.hit;

  // Ready after one wait cycle; writes stall while an access is in flight
  always_comb begin
    nxt = r;
    nxt.pready = 1'b0;
    if (psel && penable && !r.pready && !(pwrite && rb.busy)) begin
      nxt.pready = 1'b1;
      nxt.pslverr = ~rb.hit; // Unmapped address
      nxt.prdata = (!pwrite && rb.hit) ? rb.rdata : 32'h0000_0000;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
endmodule // fle_apb_slave
`default_nettype wire

//--- rtl/fle_defines.svh
// Constants for the flag and load/store execution block.
// Assumes inclusion by bare name from the rtl folder.
`ifndef FLE_DEFINES_SVH
`define FLE_DEFINES_SVH

// Register offsets on the APB window (byte addresses)
`define FLE_OFF_INSTR 8'h00
`define FLE_OFF_KWORD 8'h04
`define FLE_OFF_FLAGS 8'h08
`define FLE_OFF_STAT 8'h0c
`define FLE_RF_BIT 7

// Instruction word fields
`define FLE_OP_MSB 3
`define FLE_OP_LSB 0
`define FLE_RD_MSB 8
`define FLE_RD_LSB 4
`define FLE_SRC_MSB 13
`define FLE_SRC_LSB 9
`define FLE_IMM_MSB 21
`define FLE_IMM_LSB 14
`define FLE_FIDX_MSB 16
`define FLE_Q_MSB 19
`define FLE_SEL_MSB 23
`define FLE_SEL_LSB 22
`define FLE_MODE_MSB 25
`define FLE_MODE_LSB 24

// Pointer selects and addressing modes
`define FLE_SEL_X 2'd0
`define FLE_SEL_Y 2'd1
`define FLE_SEL_Z 2'd2
`define FLE_MODE_PLAIN 2'd0
`define FLE_MODE_POSTINC 2'd1
`define FLE_MODE_PREDEC 2'd2

// Low register of each pointer pair
`define FLE_PTR_X_LO 5'd26
`define FLE_PTR_Y_LO 5'd28
`define FLE_PTR_Z_LO 5'd30

// Status bits and reset values
`define FLE_STAT_BUSY 0
`define FLE_STAT_BAD 1
`define FLE_FLAGS_RST 8'h00

`endif

//--- rtl/fle_exec.sv
// Flag and load/store execution core with APB register access.
// Assumes a data memory on CLK whose read data is valid combinationally
// in the cycle that DM_RE is high.
//
// How it works
// [RQ1] Carry clear zeroes C; negative raise sets N.
// [RQ2] Sign raise/drop set or clear S, one cycle.
// [RQ3] Overflow raise/drop set or clear V, one cycle.
// [RQ4] Transfer raise/drop set or clear T only.
// [RQ5] Half-carry raise/drop set or clear H.
// [RQ6] Pre-decrement load: decrement pointer, then read.
// [RQ7] Post-increment load: read, then increment pointer.
// [RQ8] Displaced load reads Y/Z plus q, pointer kept.
// [RQ9] Absolute load reads fixed address, two cycles.
// [RQ10] Post-increment store: write, then increment pointer.
// [RQ11] Pre-decrement store: decrement pointer, then write.
// [RQ12] Other flag ops and copies finish in one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "fle_defines.svh"
module fle_exec (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [15:0] DM_ADDR,
  output logic [7:0] DM_WDATA,
  output logic DM_WE,
  output logic DM_RE,
  input wire logic [7:0] DM_RDATA,
  output logic [7:0] FLAG_REG
);

  fle_pkg::fle_core_s r, nxt;
  fle_reg_if rb ();

  // Decoded instruction fields from the write data
  fle_pkg::fle_op_e op;
  logic [4:0] rd;
  logic [4:0] src;
  logic [7:0] imm;
  logic [2:0] fidx;
  logic [5:0] q;
  logic [1:0] sel;
  logic [1:0] mode;
  logic [4:0] ptr_lo;
  logic [15:0] ptr_cur;
  logic [15:0] ea;
  logic [15:0] ptr_new;
  logic disp;

  // Low register index of the selected pointer pair
  function automatic logic [4:0] ptr_index(input logic [1:0] s);
    case (s)
      `FLE_SEL_Y: ptr_index = `FLE_PTR_Y_LO;
      `FLE_SEL_Z: ptr_index = `FLE_PTR_Z_LO;
      default: ptr_index = `FLE_PTR_X_LO;
    endcase
  endfunction

  // Sixteen-bit pointer built from a register pair
  function automatic logic [15:0] pair_of(input logic [31:0][7:0] f, input logic [4:0] lo);
    pair_of = {f[lo | 5'd1], f[lo]};
  endfunction

  // Odd partner of an even register index
  function automatic logic [4:0] odd_of(input logic [4:0] n);
    odd_of = {n[4:1], 1'b1};
  endfunction

  // APB front end
  fle_apb_slave u_apb (
    .clk(CLK),
    .rst(RST),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .prdata(PRDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .rb(rb)
  );

  // Field extraction
  assign op = fle_pkg::fle_op_e'(rb.wdata[`FLE_OP_MSB:`FLE_OP_LSB]);
  assign rd = rb.wdata[`FLE_RD_MSB:`FLE_RD_LSB];
  assign src = rb.wdata[`FLE_SRC_MSB:`FLE_SRC_LSB];
  assign imm = rb.wdata[`FLE_IMM_MSB:`FLE_IMM_LSB];
  assign fidx = rb.wdata[`FLE_FIDX_MSB:`FLE_IMM_LSB];
  assign q = rb.wdata[`FLE_Q_MSB:`FLE_IMM_LSB];
  assign sel = rb.wdata[`FLE_SEL_MSB:`FLE_SEL_LSB];
  assign mode = rb.wdata[`FLE_MODE_MSB:`FLE_MODE_LSB];

  // Pointer source for indirect forms
  assign ptr_lo = ptr_index(sel);
  assign ptr_cur = pair_of(r.rf, ptr_lo);
  assign disp = (op == fle_pkg::OP_DISP_RD);

  // Address arithmetic; displaced form never uses a pointer mode
  fle_ptr_unit u_ptr (
    .ptr(ptr_cur),
    .mode(disp ? `FLE_MODE_PLAIN : mode),
    .q(q),
    .disp(disp),
    .ea(ea),
    .ptr_new(ptr_new)
  );

  // Busy while a memory access is in flight
  assign rb.busy = (r.phase == fle_pkg::PH_MEM);

  // Register read mux and address decode
  always_comb begin
    rb.rdata = 32'h0000_0000;
    rb.hit = 1'b0;
    if (rb.addr[`FLE_RF_BIT] && rb.addr[1:0] == 2'b00) begin
      rb.hit = 1'b1;
      rb.rdata = {24'h00_0000, r.rf[rb.addr[6:2]]};
    end else begin
      case (rb.addr)
        `FLE_OFF_INSTR: begin
          rb.hit = 1'b1; // Write-only, reads zero
        end
        `FLE_OFF_KWORD: begin
          rb.hit = 1'b1;
          rb.rdata = {16'h0000, r.kword};
        end
        `FLE_OFF_FLAGS: begin
          rb.hit = 1'b1;
          rb.rdata = {24'h00_0000, r.flags};
        end
        `FLE_OFF_STAT: begin
          rb.hit = 1'b1;
          rb.rdata[`FLE_STAT_BUSY] = rb.busy;
          rb.rdata[`FLE_STAT_BAD] = r.bad;
        end
        default: begin
          rb.hit = 1'b0;
        end
      endcase
    end
  end

  // Next-state logic: execution and register writes
  always_comb begin
    nxt = r;
    nxt.dm_we = 1'b0;
    nxt.dm_re = 1'b0;
    case (r.phase)
      // Second cycle: loads capture memory data, stores finish
      fle_pkg::PH_MEM: begin
        if (r.is_load) begin
          nxt.rf[r.dst] = DM_RDATA; // RQ6 RQ7 RQ8 RQ9
        end
        nxt.is_load = 1'b0;
        nxt.phase = fle_pkg::PH_IDLE;
      end
      fle_pkg::PH_IDLE: begin
        if (rb.wr && rb.addr[`FLE_RF_BIT]) begin
          // Direct register file write
          nxt.rf[rb.addr[6:2]] = rb.wdata[7:0];
        end else if (rb.wr && rb.addr == `FLE_OFF_KWORD) begin
          nxt.kword = rb.wdata[15:0];
        end else if (rb.wr && rb.addr == `FLE_OFF_FLAGS) begin
          nxt.flags = rb.wdata[7:0];
        end else if (rb.wr && rb.addr == `FLE_OFF_INSTR) begin
          nxt.bad = 1'b0;
          case (op)
            fle_pkg::OP_NOP: begin
              nxt.bad = 1'b0;
            end
            // Single flag set, one cycle, no other flag touched
            fle_pkg::OP_FSET: begin
              nxt.flags[fidx] = 1'b1; // RQ1 RQ2 RQ3 RQ4 RQ5 RQ12
            end
            // Single flag clear, one cycle, no other flag touched
            fle_pkg::OP_FCLR: begin
              nxt.flags[fidx] = 1'b0; // RQ1 RQ2 RQ3 RQ4 RQ5 RQ12
            end
            // Register copy
            fle_pkg::OP_COPY: begin
              nxt.rf[rd] = r.rf[src]; // RQ12
            end
            // Register pair copy, even indices forced
            fle_pkg::OP_PAIR: begin
              nxt.rf[{rd[4:1], 1'b0}] = r.rf[{src[4:1], 1'b0}]; // RQ12
              nxt.rf[odd_of(rd)] = r.rf[odd_of(src)]; // RQ12
            end
            // Immediate load
            fle_pkg::OP_IMM: begin
              nxt.rf[rd] = imm; // RQ12
            end
            // Indirect load in plain, post-increment or pre-decrement form
            fle_pkg::OP_IND_RD: begin
              if (sel == 2'd3 || mode == 2'd3) begin
                nxt.bad = 1'b1;
              end else begin
                nxt.dm_addr = ea; // RQ6 RQ7
                nxt.dm_re = 1'b1;
                nxt.is_load = 1'b1;
                nxt.dst = rd;
                nxt.rf[ptr_lo] = ptr_new[7:0]; // RQ6 RQ7
                nxt.rf[odd_of(ptr_lo)] = ptr_new[15:8];
                nxt.phase = fle_pkg::PH_MEM;
              end
            end
            // Displaced load through Y or Z; pointer left alone
            fle_pkg::OP_DISP_RD: begin
              if (sel == `FLE_SEL_X || sel == 2'd3) begin
                nxt.bad = 1'b1;
              end else begin
                nxt.dm_addr = ea; // RQ8
                nxt.dm_re = 1'b1;
                nxt.is_load = 1'b1;
                nxt.dst = rd;
                nxt.phase = fle_pkg::PH_MEM;
              end
            end
            // Absolute load from the address held in the k word
            fle_pkg::OP_ABS_RD: begin
              nxt.dm_addr = r.kword; // RQ9
              nxt.dm_re = 1'b1;
              nxt.is_load = 1'b1;
              nxt.dst = rd;
              nxt.phase = fle_pkg::PH_MEM;
            end
            // Indirect store in plain, post-increment or pre-decrement form
            fle_pkg::OP_IND_WR: begin
              if (sel == 2'd3 || mode == 2'd3) begin
                nxt.bad = 1'b1;
              end else begin
                nxt.dm_addr = ea; // RQ10 RQ11
                nxt.dm_wdata = r.rf[src];
                nxt.dm_we = 1'b1;
                nxt.is_load = 1'b0;
                nxt.rf[ptr_lo] = ptr_new[7:0]; // RQ10 RQ11
                nxt.rf[odd_of(ptr_lo)] = ptr_new[15:8];
                nxt.phase = fle_pkg::PH_MEM;
              end
            end
            default: begin
              nxt.bad = 1'b1; // Unknown operation refused
            end
          endcase
        end
      end
      default: begin
        nxt.phase = fle_pkg::PH_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge CLK) begin
    if (RST) begin
      r <= '0;
      r.flags <= `FLE_FLAGS_RST;
      r.phase <= fle_pkg::PH_IDLE;
    end else begin
      r <= nxt;
    end
  end

  // Outputs straight from state flip-flops
  assign DM_ADDR = r.dm_addr;
  assign DM_WDATA = r.dm_wdata;
  assign DM_WE = r.dm_we;
  assign DM_RE = r.dm_re;
  assign FLAG_REG = r.flags;

endmodule // fle_exec
`default_nettype wire

//--- rtl/fle_pkg.sv
// Types for the flag and load/store execution block.
// Assumes nothing beyond a SystemVerilog compiler.
package fle_pkg;

  // Operation codes, numbered in declaration order from zero
  typedef enum logic [3:0] {
    OP_NOP, OP_FSET, OP_FCLR, OP_COPY, OP_PAIR, OP_IMM, OP_IND_RD, OP_DISP_RD, OP_ABS_RD,
    OP_IND_WR
  } fle_op_e;

  typedef enum logic [0:0] {PH_IDLE, PH_MEM} fle_state_e;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } fle_apb_s;

  typedef struct packed {
    fle_state_e phase;
    logic [7:0] flags;
    logic [31:0][7:0] rf;
    logic [15:0] kword;
    logic bad;
    logic is_load;
    logic [4:0] dst;
    logic [15:0] dm_addr;
    logic [7:0] dm_wdata;
    logic dm_we;
    logic dm_re;
  } fle_core_s;

endpackage

//--- rtl/fle_ptr_unit.sv
// Effective address and updated pointer for indirect accesses.
// Assumes mode and displacement come from a decoded instruction.
`timescale 1ns/1ps
`default_nettype none
`include "fle_defines.svh"
module fle_ptr_unit (
  input wire logic [15:0] ptr,
  input wire logic [1:0] mode,
  input wire logic [5:0] q,
  input wire logic disp,
  output logic [15:0] ea,
  output logic [15:0] ptr_new
);
  // Pre-decrement addresses the reduced pointer; others the current one, plus q in the displaced form
  always_comb begin
    ea = ptr + (disp ? {10'h000, q} : 16'h0000);
    ptr_new = ptr;
    if (mode == `FLE_MODE_PREDEC) begin
      ptr_new = ptr - 16'h0001;
      ea = ptr_new;
    end else if (mode == `FLE_MODE_POSTINC) begin
      ptr_new = ptr + 16'h0001;
    end
  end
endmodule // fle_ptr_unit
`default_nettype wire

//--- rtl/fle_reg_if.sv
// Register access carrier between the APB slave and the core.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface fle_reg_if;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic [31:0] rdata;
  logic hit;
  logic busy;
  modport slave (output addr, output wdata, output wr, input rdata, input hit, input busy);
  modport core (input addr, input wdata, input wr, output rdata, output hit, output busy);
endinterface
`default_nettype wire

//--- verif/fle_exec_checker.sv
// Port assertions for the execution core.
// Assumes binding to fle_exec; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module fle_exec_checker (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [15:0] DM_ADDR,
  input wire logic [7:0] DM_WDATA,
  input wire logic DM_WE,
  input wire logic DM_RE,
  input wire logic [7:0] DM_RDATA,
  input wire logic [7:0] FLAG_REG
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // Handshake and strobe shapes
  property p_rdy; PREADY |=> !PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("pready not a pulse");
  property p_we; DM_WE |=> !DM_WE && !DM_RE; endproperty
  a_we: assert property (p_we) else $error("store strobe too long");
  property p_re; DM_RE |=> !DM_RE && !DM_WE; endproperty
  a_re: assert property (p_re) else $error("load strobe too long");
  property p_excl; DM_WE |-> !DM_RE; endproperty
  a_excl: assert property (p_excl) else $error("read and write at once");
  // Memory access only in the cycle after a write handshake
  property p_start; (DM_RE || DM_WE) |-> $past(PREADY) && $past(PWRITE); endproperty
  a_start: assert property (p_start) else $error("memory access late");
  // Flags move only right after a handshake, never during memory access
  property p_fcause; !$stable(FLAG_REG) |-> $past(PREADY) || PREADY; endproperty
  a_fcause: assert property (p_fcause) else $error("flags moved alone");
  property p_fkeep; (DM_RE || DM_WE) |-> $stable(FLAG_REG); endproperty
  a_fkeep: assert property (p_fkeep) else $error("flags moved by access");
  // Slave error and read data rules
  property p_unm; PREADY && PADDR == 8'h10 |-> PSLVERR && PRDATA == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped not refused");
  property p_map; PREADY && PADDR[7] |-> !PSLVERR; endproperty
  a_map: assert property (p_map) else $error("register refused");
  property p_wz; PREADY && PWRITE |-> PRDATA == 32'h0; endproperty
  a_wz: assert property (p_wz) else $error("write returned data");
endmodule // fle_exec_checker
`default_nettype wire

//--- verif/fle_exec_test.sv
// Testbench for the execution core: APB master tasks and sequences.
// Assumes the memory model and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module fle_exec_test;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic [15:0] DM_ADDR;
  logic [7:0] DM_WDATA;
  logic DM_WE;
  logic DM_RE;
  logic [7:0] DM_RDATA;
  logic [7:0] FLAG_REG;
  logic [31:0] rd_v;
  logic err_v;
  logic [7:0] fexp;
  int n_errors = 0;
  int checks = 0;
  // 200 MHz clock
  always #2.5 CLK = ~CLK;
  fle_exec u_fle_exec (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DM_ADDR(DM_ADDR), .DM_WDATA(DM_WDATA), .DM_WE(DM_WE), .DM_RE(DM_RE),
    .DM_RDATA(DM_RDATA), .FLAG_REG(FLAG_REG));
  fle_mem_model u_fle_mem_model (.CLK(CLK), .DM_ADDR(DM_ADDR), .DM_WDATA(DM_WDATA),
    .DM_WE(DM_WE), .DM_RE(DM_RE), .DM_RDATA(DM_RDATA));
  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1) begin
      n_errors++;
      report_and_stop();
    end
    rd_v = PRDATA;
    err_v = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    cmp_word(nm, e, rd_v);
  endtask
  function automatic logic [31:0] ins(input logic [3:0] op, input logic [4:0] rd, rs,
    input logic [7:0] imm, input logic [1:0] sel, mode);
    return {6'h0, mode, sel, imm, rs, rd, op};
  endfunction
  function automatic logic [31:0] mp(input logic [15:0] a);
    return {24'h0, a[7:0] ^ a[15:8] ^ 8'h3c};
  endfunction
  // Main sequence
  initial begin
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    rdc(8'h08, 32'h0, "flags reset");
    rdc(8'h10, 32'h0, "unmapped");
    cmp_byte("slverr", 8'h01, {7'h0, err_v});
    $display("test reset done");
    fexp = 8'h00;
    for (int i = 0; i < 8; i++) begin
      fexp[i] = 1'b1;
      wr(8'h00, ins(fle_pkg::OP_FSET, 5'h0, 5'h0, 8'(i), 2'h0, 2'h0));
      rdc(8'h08, {24'h0, fexp}, "flags set");
      cmp_byte("flag port", fexp, FLAG_REG);
    end
    for (int i = 0; i < 8; i++) begin
      fexp[i] = 1'b0;
      wr(8'h00, ins(fle_pkg::OP_FCLR, 5'h0, 5'h0, 8'(i), 2'h0, 2'h0));
      rdc(8'h08, {24'h0, fexp}, "flags clear");
    end
    $display("test flags done");
    wr(8'h00, ins(fle_pkg::OP_IMM, 5'd16, 5'd0, 8'ha5, 2'h0, 2'h0));
    wr(8'h00, ins(fle_pkg::OP_COPY, 5'd17, 5'd16, 8'h0, 2'h0, 2'h0));
    rdc({1'b1, 5'd17, 2'b00}, 32'ha5, "copy");
    wr({1'b1, 5'd17, 2'b00}, 32'h5a);
    wr(8'h00, ins(fle_pkg::OP_PAIR, 5'd2, 5'd16, 8'h0, 2'h0, 2'h0));
    rdc({1'b1, 5'd2, 2'b00}, 32'ha5, "pair lo");
    rdc({1'b1, 5'd3, 2'b00}, 32'h5a, "pair hi");
    $display("test copies done");
    wr({1'b1, 5'd26, 2'b00}, 32'h20);
    wr({1'b1, 5'd27, 2'b00}, 32'h01);
    wr(8'h00, ins(fle_pkg::OP_IND_RD, 5'd5, 5'd0, 8'h0, 2'h0, 2'h1));
    rdc({1'b1, 5'd5, 2'b00}, mp(16'h0120), "postinc data");
    rdc({1'b1, 5'd26, 2'b00}, 32'h21, "postinc ptr");
    wr({1'b1, 5'd28, 2'b00}, 32'h00);
    wr({1'b1, 5'd29, 2'b00}, 32'h02);
    wr(8'h00, ins(fle_pkg::OP_IND_RD, 5'd6, 5'd0, 8'h0, 2'h1, 2'h2));
    rdc({1'b1, 5'd6, 2'b00}, mp(16'h01ff), "predec data");
    rdc({1'b1, 5'd29, 2'b00}, 32'h01, "predec ptr");
    wr({1'b1, 5'd30, 2'b00}, 32'h00);
    wr({1'b1, 5'd31, 2'b00}, 32'h03);
    wr(8'h00, ins(fle_pkg::OP_DISP_RD, 5'd9, 5'd0, 8'h05, 2'h2, 2'h0));
    rdc({1'b1, 5'd9, 2'b00}, mp(16'h0305), "disp data");
    rdc({1'b1, 5'd30, 2'b00}, 32'h00, "disp ptr");
    wr(8'h04, 32'h0456);
    wr(8'h00, ins(fle_pkg::OP_ABS_RD, 5'd10, 5'd0, 8'h0, 2'h0, 2'h0));
    rdc({1'b1, 5'd10, 2'b00}, mp(16'h0456), "direct data");
    $display("test loads done");
    wr({1'b1, 5'd7, 2'b00}, 32'h9c);
    wr(8'h00, ins(fle_pkg::OP_IND_WR, 5'd0, 5'd7, 8'h0, 2'h0, 2'h1));
    rdc({1'b1, 5'd26, 2'b00}, 32'h22, "store inc ptr");
    cmp_byte("mem 0121", 8'h9c, u_fle_mem_model.mem[16'h0121]);
    wr({1'b1, 5'd8, 2'b00}, 32'h3e);
    wr(8'h00, ins(fle_pkg::OP_IND_WR, 5'd0, 5'd8, 8'h0, 2'h1, 2'h2));
    rdc({1'b1, 5'd28, 2'b00}, 32'hfe, "store dec ptr");
    cmp_byte("mem 01fe", 8'h3e, u_fle_mem_model.mem[16'h01fe]);
    rdc(8'h0c, 32'h0, "status idle");
    $display("test stores done");
    wr(8'h00, ins(4'hf, 5'd0, 5'd0, 8'h0, 2'h0, 2'h0));
    rdc(8'h0c, 32'h2, "bad op");
    wr(8'h00, ins(fle_pkg::OP_NOP, 5'd0, 5'd0, 8'h0, 2'h0, 2'h0));
    rdc(8'h0c, 32'h0, "refusal cleared");
    wr(8'h00, ins(fle_pkg::OP_DISP_RD, 5'd11, 5'd0, 8'h01, 2'h0, 2'h0));
    rdc(8'h0c, 32'h2, "disp via x");
    wr(8'h00, ins(fle_pkg::OP_NOP, 5'd0, 5'd0, 8'h0, 2'h0, 2'h0));
    wr(8'h00, ins(fle_pkg::OP_IND_RD, 5'd11, 5'd0, 8'h0, 2'h3, 2'h0));
    rdc(8'h0c, 32'h2, "pointer sel 3");
    rdc({1'b1, 5'd11, 2'b00}, 32'h0, "refused load kept");
    $display("test refusals done");
    report_and_stop();
  end
endmodule // fle_exec_test
bind fle_exec fle_exec_checker u_fle_exec_checker (.CLK(CLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .DM_ADDR(DM_ADDR), .DM_WDATA(DM_WDATA),
  .DM_WE(DM_WE), .DM_RE(DM_RE), .DM_RDATA(DM_RDATA), .FLAG_REG(FLAG_REG));
`default_nettype wire

//--- verif/fle_mem_model.sv
// Byte-wide data memory answering the core's loads and stores.
// Assumes the core clock and one-cycle read and write strobes.
`timescale 1ns/1ps
`default_nettype none
module fle_mem_model (
  input wire logic CLK,
  input wire logic [15:0] DM_ADDR,
  input wire logic [7:0] DM_WDATA,
  input wire logic DM_WE,
  input wire logic DM_RE,
  output logic [7:0] DM_RDATA
);
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;
  // Preload each byte with a pattern of its address
  initial begin
    for (int a = 0; a < 65536; a++) begin
      mem[a] = a[7:0] ^ a[15:8] ^ 8'h3c;
    end
  end
  // Data only while selected, else the inverse of the last byte read
  assign DM_RDATA = DM_RE ? mem[DM_ADDR] : ~last;
  // Store at the edge that ends the strobe cycle
  always @(posedge CLK) begin
    if (DM_WE) begin
      mem[DM_ADDR] <= DM_WDATA;
    end
    if (DM_RE) begin
      last <= mem[DM_ADDR];
    end
  end
endmodule // fle_mem_model
`default_nettype wire
